// file: rtl/pld_array_cfg.svh
//////////////////////////////////////////////////////////////////////////////
// Purpose: Layout constants of the macrocell array
// Assumes: 24 macrocells, two flip-flops each, 17 product terms per cell
// Notes:   Preset terms follow the cell terms in the product-term memory
//////////////////////////////////////////////////////////////////////////////
`ifndef PLD_ARRAY_CFG_SVH
`define PLD_ARRAY_CFG_SVH

// Product-term slots inside one macrocell
`define PT_PER_MC        17
`define PT_PER_SUM       4
`define PT_SUM_A         0
`define PT_SUM_B         4
`define PT_SUM_C         8
`define PT_CLK           12
`define PT_RST           14
`define PT_OE            16

// Synchronous preset terms and their flip-flop groups
`define PRESET_TERMS     8
`define PRESET_WIDE_CNT  4
`define PRESET_WIDE_SIZE 8
`define PRESET_NARROW    4
`define PRESET_FLOPS     48

// Pins and storage
`define PIN_CLOCK_INDEX  0
`define USER_ROW_BITS    64
`define FLOP_RESET_VALUE 1'b0

`endif

// file: rtl/pld_types_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Types that carry per-flop and per-cell configuration
// Assumes: Configuration is static while the array runs
// Notes:   Offsets and counts live in pld_array_cfg.svh
//////////////////////////////////////////////////////////////////////////////
package pld_types_pkg;

	// Per flip-flop options
	typedef struct packed {
		logic t_type;
		logic pin_clock;
	} flop_cfg_type;

	// Per macrocell options
	typedef struct packed {
		logic combine;
		logic bypass;
		logic invert;
	} cell_cfg_type;

	// Test load pins
	typedef struct packed {
		logic enable;
		logic strobe;
		logic q_select;
		logic even_odd;
	} preload_pins_type;

endpackage : pld_types_pkg

// file: rtl/pld_macrocell_array.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Product-term array, 24 macrocells, 48 configurable flip-flops
// Assumes: mclk 10 MHz; all pins asynchronous to mclk; fuse load on mclk
// Notes:   Term clocks and pin clock act as rising-edge enables on mclk
// How it works
// - Every pin and every flip-flop output feeds every product term.
// - Each sum term ORs four product terms.
// - Combine mode merges a cell's three sum terms into twelve terms.
// - Each flip-flop selects D or T behaviour on its own.
// - Bypass skips the second register, its sum feeds the array.
// - Each flip-flop has its own clock term and reset term.
// - Each flip-flop may take the dedicated pin clock instead.
// - Each output has its own enable term; false releases the pin.
// - Eight preset terms set groups of eight or four flops on clock.
// - Two flip-flops per cell, 48 total, each with own terms.
// - Pin inputs and register feedback enter the array separately.
// - A test load forces any value into the registers.
// - Reset clears every register without further action.
// - Reset leaves registers low; pin level follows output polarity.
// - With keepers on, floating pins hold their last driven level.
// - A 64-bit user row stores free information.
// - Test load writes odd I/O pin levels into selected registers.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
`include "pld_array_cfg.svh"

module pld_macrocell_array #(
	parameter int NUM_IN = 14,
	parameter int NUM_MC = 24,
	parameter int ADDR_W = 9
) (
	input  wire logic                                  mclk,
	input  wire logic                                  resetn,
	input  wire logic [NUM_IN-1:0]                     in_pin,
	input  wire logic [NUM_IN-1:0]                     in_float,
	input  wire logic [NUM_MC-1:0]                     io_in,
	input  wire logic [NUM_MC-1:0]                     io_float,
	input  wire pld_types_pkg::preload_pins_type       preload,
	input  wire pld_types_pkg::flop_cfg_type [2*NUM_MC-1:0] flop_cfg,
	input  wire pld_types_pkg::cell_cfg_type [NUM_MC-1:0]   cell_cfg,
	input  wire logic                                  keeper_enable,
	input  wire logic                                  observe_second,
	input  wire logic                                  fuse_write,
	input  wire logic [ADDR_W-1:0]                     fuse_addr,
	input  wire logic [2*(NUM_IN+3*NUM_MC)-1:0]        fuse_data,
	input  wire logic                                  user_row_write,
	input  wire logic [`USER_ROW_BITS-1:0]             user_row_data,
	output var  logic [NUM_MC-1:0]                     io_out,
	output var  logic [NUM_MC-1:0]                     io_oe_n,
	output var  logic [2*NUM_MC-1:0]                   flop_state,
	output var  logic [`USER_ROW_BITS-1:0]             user_row
);
	import pld_types_pkg::*;

	localparam int NUM_FF  = 2 * NUM_MC;
	localparam int NUM_PIN = NUM_IN + NUM_MC;
	localparam int NUM_ARR = NUM_PIN + NUM_FF;
	localparam int ROW_W   = 2 * NUM_ARR;
	localparam int NUM_PT  = NUM_MC * `PT_PER_MC + `PRESET_TERMS;
	localparam int SYNC_W  = 2 * NUM_PIN + 4;

	// Elaboration checks on the shape
	if (NUM_FF != `PRESET_FLOPS || NUM_MC % 4 != 0) begin : g_bad_flops
		$error("NUM_MC must give 48 flops in preset groups");
	end
	if (NUM_IN < 1) begin : g_bad_inputs
		$error("NUM_IN must be at least one");
	end
	if ((1 << ADDR_W) < NUM_PT) begin : g_bad_addr
		$error("ADDR_W too small for the product-term memory");
	end

	// True when every enabled literal holds; blank row is false
	function automatic logic pt_true(input logic [ROW_W-1:0] row,
			input logic [NUM_ARR-1:0] x);
		logic hit;
		hit = |row;
		hit = hit & (&(~row[NUM_ARR-1:0] | x));
		hit = hit & (&(~row[ROW_W-1:NUM_ARR] | ~x));
		return hit;
	endfunction : pt_true

	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [SYNC_W-1:0] sync1_reg, sync1_next;
	logic [SYNC_W-1:0] sync2_reg, sync2_next;

	// Two flops ahead of any pin reader
	always_comb begin
		sync1_next = {preload, io_float, in_float, io_in, in_pin};
		sync2_next = sync1_reg;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
		end
	end

	logic [NUM_PIN-1:0] pin_sync;
	logic [NUM_PIN-1:0] pin_floating;
	preload_pins_type   pre_sync;

	// Unpack synchronised pins
	assign pin_sync     = sync2_reg[NUM_PIN-1:0];
	assign pin_floating = sync2_reg[2*NUM_PIN-1:NUM_PIN]; // Same order as pin_sync
	assign pre_sync     = preload_pins_type'(sync2_reg[SYNC_W-1:2*NUM_PIN]);

	//////////////////////////////////////////////////////////////////////////
	// Pin keepers and pin-clock edge
	logic [NUM_PIN-1:0] keep_reg, keep_next;
	logic [NUM_PIN-1:0] pin_val;
	logic               pin_clk_prev_reg, pin_clk_prev_next;
	logic               strobe_prev_reg, strobe_prev_next;
	logic               pin_edge;
	logic               preload_pulse;

	// Floating pins read back the kept level
	always_comb begin
		keep_next         = (pin_floating & keep_reg) | (~pin_floating & pin_sync);
		pin_val           = keeper_enable ? keep_next : pin_sync;
		pin_clk_prev_next = pin_val[`PIN_CLOCK_INDEX];
		strobe_prev_next  = pre_sync.strobe;
		pin_edge          = pin_val[`PIN_CLOCK_INDEX] & ~pin_clk_prev_reg;
		preload_pulse     = pre_sync.enable & pre_sync.strobe & ~strobe_prev_reg;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			keep_reg         <= '0;
			pin_clk_prev_reg <= 1'b0;
			strobe_prev_reg  <= 1'b0;
		end else begin
			keep_reg         <= keep_next;
			pin_clk_prev_reg <= pin_clk_prev_next;
			strobe_prev_reg  <= strobe_prev_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Product-term memory, written from the fuse port
	logic [ROW_W-1:0] fuse_mem [NUM_PT];

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			for (int p = 0; p < NUM_PT; p++)
				fuse_mem[p] <= '0;
		end else if (fuse_write && int'(fuse_addr) < NUM_PT) begin
			fuse_mem[fuse_addr] <= fuse_data;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Array inputs and product terms
	logic [NUM_FF-1:0]  q_reg, q_next;
	logic [NUM_MC-1:0]  bypass_reg, bypass_next;
	logic [NUM_FF-1:0]  fb;
	logic [NUM_ARR-1:0] arr_in;
	logic [NUM_PT-1:0]  pt;

	// Pins and feedback as separate array columns
	assign arr_in = {fb, pin_val};

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PT; gp++) begin : g_pt
			assign pt[gp] = pt_true(fuse_mem[gp], arr_in);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// Per-cell sum terms and per-flop controls
	logic [NUM_MC-1:0] sum_a, sum_b, sum_c;
	logic [NUM_MC-1:0] oe_term;
	logic [NUM_FF-1:0] sum_in;
	logic [NUM_FF-1:0] clk_term, clk_edge;
	logic [NUM_FF-1:0] clk_prev_reg, clk_prev_next;
	logic [NUM_FF-1:0] rst_term;
	logic [NUM_FF-1:0] preset_term;
	logic [NUM_FF-1:0] preload_hit;
	logic [NUM_FF-1:0] preload_val;

	genvar gm, gr;
	generate
		for (gm = 0; gm < NUM_MC; gm++) begin : g_cell
			localparam int B = gm * `PT_PER_MC;

			// Four terms per sum
			assign sum_a[gm] = |pt[B+`PT_SUM_A +: `PT_PER_SUM];
			assign sum_b[gm] = |pt[B+`PT_SUM_B +: `PT_PER_SUM];
			assign sum_c[gm] = |pt[B+`PT_SUM_C +: `PT_PER_SUM];
			assign oe_term[gm] = pt[B+`PT_OE];

			// First flop may take all twelve terms
			assign sum_in[2*gm] = cell_cfg[gm].combine ?
				(sum_a[gm] | sum_b[gm] | sum_c[gm]) : sum_a[gm];
			assign sum_in[2*gm+1] = sum_b[gm];

			// Bypassed second register feeds its sum back
			assign fb[2*gm]   = q_reg[2*gm];
			assign fb[2*gm+1] = cell_cfg[gm].bypass ? bypass_reg[gm]
				: q_reg[2*gm+1];

			for (gr = 0; gr < 2; gr++) begin : g_flop
				localparam int F = 2 * gm + gr;
				localparam int G = (F < `PRESET_WIDE_CNT * `PRESET_WIDE_SIZE) ?
					F / `PRESET_WIDE_SIZE :
					`PRESET_WIDE_CNT + (F - `PRESET_WIDE_CNT * `PRESET_WIDE_SIZE)
					/ `PRESET_NARROW;
				localparam int PIN = NUM_IN + 2 * (gm / 2) + 1;

				assign clk_term[F] = pt[B+`PT_CLK+gr];
				assign rst_term[F] = pt[B+`PT_RST+gr];
				assign preset_term[F] = pt[NUM_MC*`PT_PER_MC+G];

				// Own clock term or dedicated pin clock
				assign clk_edge[F] = flop_cfg[F].pin_clock ? pin_edge
					: (clk_term[F] & ~clk_prev_reg[F]);

				// Odd I/O pin level into the selected register
				assign preload_hit[F] = preload_pulse
					& (pre_sync.even_odd == 1'(gm % 2))
					& (pre_sync.q_select == 1'(gr));
				assign preload_val[F] = pin_val[PIN];
			end
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// Flip-flop state

	// Priority: test load, reset term, preset, D or T load
	always_comb begin
		q_next        = q_reg;
		clk_prev_next = clk_term;
		bypass_next   = sum_b;
		for (int f = 0; f < NUM_FF; f++) begin
			if (preload_hit[f]) begin
				q_next[f] = preload_val[f];
			end else if (rst_term[f]) begin
				q_next[f] = `FLOP_RESET_VALUE;
			end else if (clk_edge[f]) begin
				if (preset_term[f])
					q_next[f] = 1'b1;
				else if (flop_cfg[f].t_type)
					q_next[f] = q_reg[f] ^ sum_in[f];
				else
					q_next[f] = sum_in[f];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			q_reg        <= {NUM_FF{`FLOP_RESET_VALUE}};
			clk_prev_reg <= '0;
			bypass_reg   <= '0;
		end else begin
			q_reg        <= q_next;
			clk_prev_reg <= clk_prev_next;
			bypass_reg   <= bypass_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Output drivers, state view and user row
	logic [NUM_MC-1:0]         io_out_next;
	logic [NUM_MC-1:0]         io_oe_n_next;
	logic [`USER_ROW_BITS-1:0] user_row_next;

	// Pin level after polarity; optional second-register view
	always_comb begin
		for (int m = 0; m < NUM_MC; m++) begin
			io_out_next[m] = (observe_second ? q_reg[2*m+1] : q_reg[2*m])
				^ cell_cfg[m].invert;
		end
		io_oe_n_next  = ~oe_term;
		user_row_next = user_row_write ? user_row_data : user_row;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			io_out     <= '0;
			io_oe_n    <= '1;
			flop_state <= '0;
			user_row   <= '0;
		end else begin
			io_out     <= io_out_next;
			io_oe_n    <= io_oe_n_next;
			flop_state <= q_next;
			user_row   <= user_row_next;
		end
	end

endmodule : pld_macrocell_array
`default_nettype wire

// file: verif/pld_array_monitor.sv
////////////////////////////////////////////////////////////
// Purpose: Port checks of the macrocell array
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached to every array instance by bind
////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module pld_array_monitor #(parameter int NUM_MC = 24) (
	input wire logic                                     mclk,
	input wire logic                                     resetn,
	input wire logic [NUM_MC-1:0]                        io_in,
	input wire pld_types_pkg::preload_pins_type          preload,
	input wire pld_types_pkg::cell_cfg_type [NUM_MC-1:0] cell_cfg,
	input wire logic                                     observe_second,
	input wire logic                                     user_row_write,
	input wire logic [63:0]                              user_row_data,
	input wire logic [NUM_MC-1:0]                        io_out,
	input wire logic [NUM_MC-1:0]                        io_oe_n,
	input wire logic [2*NUM_MC-1:0]                      flop_state,
	input wire logic [63:0]                              user_row
);
	import pld_types_pkg::*;
	logic [NUM_MC-1:0] out_exp;
	// Pin level due from the shown flop and its polarity
	always_comb begin
		for (int m = 0; m < NUM_MC; m++) begin
			out_exp[m] = (observe_second ? flop_state[2*m+1] : flop_state[2*m]) ^ cell_cfg[m].invert;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	property p_reset_flops; $rose(resetn) |-> flop_state == '0; endproperty
	a_reset_flops: assert property (p_reset_flops) else $error("flops not clear");
	property p_reset_out; $rose(resetn) |-> io_out == '0; endproperty
	a_reset_out: assert property (p_reset_out) else $error("pins not low");
	property p_reset_oe; $rose(resetn) |-> io_oe_n == '1; endproperty
	a_reset_oe: assert property (p_reset_oe) else $error("pin driven after reset");
	property p_reset_user; $rose(resetn) |-> user_row == '0; endproperty
	a_reset_user: assert property (p_reset_user) else $error("user row not clear");
	property p_user_load; user_row_write |=> user_row == $past(user_row_data); endproperty
	a_user_load: assert property (p_user_load) else $error("user row not loaded");
	property p_user_hold; !user_row_write |=> $stable(user_row); endproperty
	a_user_hold: assert property (p_user_hold) else $error("user row moved");
	property p_out_map; 1'b1 |=> io_out == $past(out_exp); endproperty
	a_out_map: assert property (p_out_map) else $error("pin level wrong");
	property p_load_q1;
		$rose(preload.strobe) && preload.enable && !preload.q_select && !preload.even_odd
		|-> ##3 flop_state[0] == $past(io_in[1], 3);
	endproperty
	a_load_q1: assert property (p_load_q1) else $error("test load first flop");
	property p_load_q2;
		$rose(preload.strobe) && preload.enable && preload.q_select && preload.even_odd
		|-> ##3 flop_state[3] == $past(io_in[1], 3);
	endproperty
	a_load_q2: assert property (p_load_q2) else $error("test load second flop");
	c_load: cover property ($rose(preload.strobe) && preload.enable);
	c_user: cover property (user_row_write);
	c_drive: cover property (io_oe_n != '1);
endmodule : pld_array_monitor
bind pld_macrocell_array pld_array_monitor #(.NUM_MC(NUM_MC)) u_pld_array_monitor (
	.mclk(mclk), .resetn(resetn), .io_in(io_in), .preload(preload), .cell_cfg(cell_cfg),
	.observe_second(observe_second), .user_row_write(user_row_write),
	.user_row_data(user_row_data), .io_out(io_out), .io_oe_n(io_oe_n),
	.flop_state(flop_state), .user_row(user_row));
`default_nettype wire

// file: verif/pld_board_model.sv
////////////////////////////////////////////////////////////
// Purpose: Board logic on the I/O pins
// Assumes: Board drives every pin that the array releases
// Notes:   Pin levels follow one mclk after a change
////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module pld_board_model (
	input  wire logic        mclk,
	input  wire logic [23:0] io_out,
	input  wire logic [23:0] io_oe_n,
	input  wire logic [23:0] drive,
	output var  logic [23:0] io_in,
	output var  logic [23:0] io_float
);
	// Device level where it drives, board level where released
	initial io_in = '0;
	always @(posedge mclk) begin
		io_in <= (io_oe_n & drive) | (~io_oe_n & io_out);
	end
	assign io_float = '0;
endmodule : pld_board_model
`default_nettype wire

// file: verif/pld_macrocell_array_bench.sv
////////////////////////////////////////////////////////////
// Purpose: Self-checking bench of the macrocell array
// Assumes: 100 ns mclk, inputs change 1 ns after the edge
// Notes:   Pins need two cycles to pass the synchronisers
////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module pld_macrocell_array_bench;
	import pld_types_pkg::*;
	typedef struct packed {logic [1:0] sel; logic [63:0] val;} note_type;
	logic                 mclk = 1'b0, resetn = 1'b0, fuse_write = 1'b0, user_row_write = 1'b0;
	logic                 keeper_enable = 1'b0, observe_second = 1'b0;
	logic [13:0]          in_pin = '0, in_float = '0;
	logic [23:0]          io_in, io_float, io_out, io_oe_n, drive;
	preload_pins_type     preload = '0;
	flop_cfg_type [47:0]  flop_cfg = '0;
	cell_cfg_type [23:0]  cell_cfg = '0;
	logic [8:0]           fuse_addr = '0;
	logic [171:0]         fuse_data = '0;
	logic [63:0]          user_row_data = '0, user_row, ur;
	logic [47:0]          flop_state, fs = '0;
	int                   errors = 0, checks = 0, seed = 32;
	int                   rows[8] = '{0, 17, 16, 14, 4, 13, 8, 408};
	int                   lits[8] = '{1, 1, 3, 2, 6, 5, 7, 4};
	note_type             q[$];
	event                 seen;

	pld_macrocell_array u_pld_macrocell_array (.mclk(mclk), .resetn(resetn), .in_pin(in_pin),
		.in_float(in_float), .io_in(io_in), .io_float(io_float), .preload(preload),
		.flop_cfg(flop_cfg), .cell_cfg(cell_cfg), .keeper_enable(keeper_enable),
		.observe_second(observe_second),
		.fuse_write(fuse_write), .fuse_addr(fuse_addr), .fuse_data(fuse_data),
		.user_row_write(user_row_write), .user_row_data(user_row_data), .io_out(io_out),
		.io_oe_n(io_oe_n), .flop_state(flop_state), .user_row(user_row));
	pld_board_model u_pld_board_model (.mclk(mclk), .io_out(io_out), .io_oe_n(io_oe_n),
		.drive(drive), .io_in(io_in), .io_float(io_float));

	always #50 mclk = ~mclk;
	task tick(input int n); repeat (n) @(posedge mclk); #1; endtask : tick
	task note(input logic [1:0] s, input logic [63:0] v); q.push_back({s, v}); ->seen; endtask : note
	task pulse(input int k); tick(4); in_pin[k] = 1'b1; tick(4); in_pin[k] = 1'b0; tick(4); endtask : pulse
	task results;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////
	// Compare each queued note with the output it names
	always @(seen) begin : watch
		note_type n;
		logic [63:0] got;
		while (q.size() > 0) begin
			n = q.pop_front();
			got = n.sel == 2'h0 ? {16'h0, flop_state} : n.sel == 2'h1 ? {40'h0, io_oe_n}
				: n.sel == 2'h2 ? user_row : {40'h0, io_out};
			checks++;
			if (got !== n.val) begin
				errors++;
				$display("wrong value at %0t: got %h expected %h", $time, got, n.val);
			end
		end
	end

	// Watchdog, far beyond the 160 cycles of the run
	initial begin
		#200000;
		errors++;
		results();
	end

	// Main sequence
	initial begin : main
		logic [23:0] drv;
		logic [23:0] exp_out;
		drive = '0;
		flop_cfg[0].pin_clock = 1'b1;
		flop_cfg[2] = 2'h3;
		tick(4);
		resetn = 1'b1;
		tick(1);
		note(2'h0, 64'h0);
		note(2'h1, 64'hff_ffff);
		note(2'h2, 64'h0);
		note(2'h3, 64'h0);
		$display("test reset finished");
		ur = {$random(seed), $random(seed)};
		user_row_data = ur;
		user_row_write = 1'b1;
		tick(1);
		user_row_write = 1'b0;
		note(2'h2, ur);
		fuse_write = 1'b1;
		foreach (rows[i]) begin
			fuse_addr = rows[i][8:0];
			fuse_data = '0;
			fuse_data[lits[i]] = 1'b1;
			tick(1);
		end
		fuse_write = 1'b0;
		in_pin[1] = 1'b1;
		pulse(0);
		fs[0] = 1'b1;
		fs[2] = 1'b1;
		note(2'h0, {16'h0, fs});
		pulse(0);
		fs[2] = 1'b0;
		note(2'h0, {16'h0, fs});
		in_pin[1] = 1'b0;
		in_pin[7] = 1'b1;
		pulse(0);
		fs[0] = 1'b0;
		note(2'h0, {16'h0, fs});
		cell_cfg[0].combine = 1'b1;
		pulse(0);
		fs[0] = 1'b1;
		note(2'h0, {16'h0, fs});
		$display("test sum and flop types finished");
		in_pin[3] = 1'b1;
		in_pin[6] = 1'($random(seed));
		pulse(5);
		fs[1] = in_pin[6];
		note(2'h1, 64'hff_fffe);
		note(2'h0, {16'h0, fs});
		in_pin[2] = 1'b1;
		tick(4);
		fs[0] = 1'b0;
		note(2'h0, {16'h0, fs});
		in_pin[4] = 1'b1;
		pulse(0);
		fs[2] = 1'b1;
		note(2'h0, {16'h0, fs});
		$display("test terms finished");
		in_pin[2] = 1'b0;
		in_pin[4] = 1'b0;
		keeper_enable = 1'b1;
		in_pin[6] = ~fs[1];
		tick(4);
		in_float[6] = 1'b1;
		in_pin[6] = fs[1];
		pulse(5);
		fs[1] = ~fs[1];
		note(2'h0, {16'h0, fs});
		in_float[6] = 1'b0;
		keeper_enable = 1'b0;
		$display("test keeper finished");
		for (int c = 0; c < 4; c++) begin
			drv = 24'($random(seed));
			drive = drv;
			preload = {1'b1, 1'b0, c[1], c[0]};
			tick(4);
			preload.strobe = 1'b1;
			tick(4);
			preload.strobe = 1'b0;
			tick(4);
			for (int m = 0; m < 24; m++) if (m % 2 == c[0]) fs[2*m+c[1]] = drv[2*(m/2)+1];
			note(2'h0, {16'h0, fs});
		end
		$display("test load finished");
		for (int m = 0; m < 24; m++) exp_out[m] = fs[2*m];
		note(2'h3, {40'h0, exp_out});
		observe_second = 1'b1;
		cell_cfg[5].invert = 1'b1;
		tick(2);
		for (int m = 0; m < 24; m++) exp_out[m] = fs[2*m+1] ^ 1'(m == 5);
		note(2'h3, {40'h0, exp_out});
		$display("test pin view finished");
		resetn = 1'b0;
		tick(2);
		resetn = 1'b1;
		tick(1);
		note(2'h0, 64'h0);
		note(2'h1, 64'hff_ffff);
		note(2'h3, 64'h20);
		note(2'h2, 64'h0);
		$display("test second reset finished");
		tick(1);
		results();
	end
endmodule : pld_macrocell_array_bench
`default_nettype wire
